// File: logic/run_command_source_arbiter.v
// Operation
// - Selection 01 terminals, 02 keypad, 03 fieldbus, 04 option board.
// - Selection 04 takes start and stop from the option board; an accepted keypad stop also stops.
// - Running needs a valid frequency command besides a run command.
// - Keypad override makes keypad run and stop keys the command source.
// - Terminal override makes terminal inputs the command source.
// - Function code 31 assigns keypad override; run and frequency go to keypad.
// - Function code 51 assigns terminal override; run and frequency go to terminals.
// - Override frequency: keypad parameter or terminal analog input.
// - Override change while running stops; restart needs run off then on.
// - Keypad override wins over terminal override.
// - Functions not assigned to the seven terminals read as off.
// - Stop key 00 always acts, 01 ignored, 02 trip clear only.
// - Stop-key suppression only when the keypad is not the run source.
// - In trip-only mode a stop press clears a trip, else does nothing.
// - Accepted keypad stop halts external run until run is reasserted.
// - Two-wire: forward alone, reverse alone run; none or both stop.
// - Three-wire: go edge with halt on starts; halt off stops.
// - Three-wire direction input off forward, on reverse.
`include "run_source_consts.vh"

module run_command_source_arbiter #(
    parameter N_TERM = 7
) (
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    input wire clk_en,
    // Settings
    input wire [7:0] run_source_select,
    input wire [7:0] stop_key_enable,
    input wire [8*N_TERM-1:0] input_function_assign,
    // Terminals and keys
    input wire [N_TERM-1:0] term_level,
    input wire key_run,
    input wire key_stop,
    input wire key_reverse,
    // Bus sources: bit 0 run, bit 1 reverse
    input wire [1:0] fieldbus_cmd,
    input wire [1:0] option_cmd,
    // Drive status
    input wire freq_valid,
    input wire tripped,
    // Outputs
    output reg run_out,
    output reg reverse_out,
    output reg [7:0] active_run_source,
    output reg freq_override,
    output reg [7:0] freq_override_source,
    output reg trip_clear
);
    wire fn_forward, fn_reverse, fn_go, fn_halt, fn_direction;
    wire fn_keypad_ovr, fn_terminal_ovr, halt_assigned;

    terminal_function_map #(.N_TERM(N_TERM)) u_map (
        .input_function_assign(input_function_assign),
        .term_level(term_level),
        .fn_forward(fn_forward),
        .fn_reverse(fn_reverse),
        .fn_go(fn_go),
        .fn_halt(fn_halt),
        .fn_direction(fn_direction),
        .fn_keypad_ovr(fn_keypad_ovr),
        .fn_terminal_ovr(fn_terminal_ovr),
        .halt_assigned(halt_assigned)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sampled history
    reg kovr_reg, tovr_reg, go_reg, key_stop_reg, key_run_reg;
    reg three_run_reg, key_latch_reg, key_rev_reg;
    reg blocked_reg;
    reg [1:0] cmd_prev_reg;
    reg [7:0] src_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Keypad as the chosen source; the stop key can never be masked then
    function is_keypad(input [7:0] source);
        is_keypad = (source == `SRC_KEYPAD);
    endfunction

    // Whether the stop/reset key has any effect at all, trip clearing included
    function key_live(input [7:0] source, input [7:0] mode);
        key_live = is_keypad(source) || (mode != `STOPKEY_OFF);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Source choice
    reg [7:0] src;
    // Keypad override is tested first, so it wins when both are on
    always @* begin
        if (fn_keypad_ovr) src = `SRC_KEYPAD;
        else if (fn_terminal_ovr) src = `SRC_TERMINAL;
        else src = run_source_select;
    end

    wire go_rise = fn_go & ~go_reg;
    wire key_stop_rise = key_stop & ~key_stop_reg;
    wire key_run_rise = key_run & ~key_run_reg;
    wire ovr_change = (fn_keypad_ovr != kovr_reg) | (fn_terminal_ovr != tovr_reg);

    // Stop key acceptance
    reg stop_accept;
    always @* begin
        if (is_keypad(src)) stop_accept = key_stop_rise;
        else begin
            case (stop_key_enable)
                `STOPKEY_ALWAYS: stop_accept = key_stop_rise;
                `STOPKEY_OFF: stop_accept = 1'b0;
                `STOPKEY_TRIP_ONLY: stop_accept = 1'b0;
                default: stop_accept = key_stop_rise;
            endcase
        end
    end

    // Three-wire latch: go edge with halt held starts, halt off stops
    // It tracks the pins even while another source is chosen
    reg three_run_next;
    always @* begin
        if (!fn_halt) three_run_next = 1'b0;
        else if (go_rise) three_run_next = 1'b1;
        else three_run_next = three_run_reg;
    end

    // Keypad latch
    reg key_latch_next;
    reg key_rev_next;
    always @* begin
        key_latch_next = key_latch_reg;
        key_rev_next = key_rev_reg;
        if (!is_keypad(src) || stop_accept) key_latch_next = 1'b0;
        else if (key_run_rise) begin
            key_latch_next = 1'b1;
            key_rev_next = key_reverse;
        end
    end

    // Raw command from chosen source
    reg [1:0] cmd;
    always @* begin
        case (src)
            `SRC_TERMINAL: begin
                if (halt_assigned) cmd = {fn_direction, three_run_reg};
                else if (fn_forward ^ fn_reverse) cmd = {fn_reverse, 1'b1};
                else cmd = `CMD_STOP;
            end
            // Keypad answers from the latch, one cycle behind the key press
            `SRC_KEYPAD: cmd = {key_rev_reg, key_latch_reg};
            `SRC_FIELDBUS: cmd = fieldbus_cmd;
            `SRC_OPTION: cmd = option_cmd;
            default: cmd = `CMD_STOP;
        endcase
    end

    wire run_req = cmd[`CMD_RUN_BIT];
    wire run_req_prev = cmd_prev_reg[`CMD_RUN_BIT];
    // Blocking rearms only on a fresh run edge from the same source, so a run
    // level that was never dropped cannot restart the motor by surprise.
    wire rearm = run_req & ~run_req_prev & (src == src_prev_reg);
    reg blocked_next;
    always @* begin
        blocked_next = blocked_reg;
        if (!run_req || rearm) blocked_next = 1'b0;
        if (run_out && ovr_change) blocked_next = 1'b1;
        if (ovr_change && run_req) blocked_next = 1'b1;
        // An accepted stop also blocks a run that is asked for but not yet
        // under way, so a stop pressed as the run arrives is never lost.
        if (stop_accept && (run_out || run_req)) blocked_next = 1'b1;
    end

    // Trip clear follows the key only where the key is live for this source
    wire trip_clear_next = key_stop_rise & tripped & key_live(src, stop_key_enable);

    ////////////////////////////////////////////////////////////////////////
    // State
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            kovr_reg <= 1'b0;
            tovr_reg <= 1'b0;
            go_reg <= 1'b0;
            key_stop_reg <= 1'b0;
            key_run_reg <= 1'b0;
            three_run_reg <= 1'b0;
            key_latch_reg <= 1'b0;
            key_rev_reg <= 1'b0;
            blocked_reg <= 1'b0;
            cmd_prev_reg <= `CMD_STOP;
            src_prev_reg <= `SRC_NONE;
            // Outputs read as stopped and unowned until the first enabled edge
            run_out <= 1'b0;
            reverse_out <= 1'b0;
            active_run_source <= `SRC_NONE;
            freq_override <= 1'b0;
            freq_override_source <= `FREQ_NONE;
            trip_clear <= 1'b0;
        end else if (clk_en) begin
            kovr_reg <= fn_keypad_ovr;
            tovr_reg <= fn_terminal_ovr;
            go_reg <= fn_go;
            key_stop_reg <= key_stop;
            key_run_reg <= key_run;
            three_run_reg <= three_run_next;
            key_latch_reg <= key_latch_next;
            key_rev_reg <= key_rev_next;
            blocked_reg <= blocked_next;
            cmd_prev_reg <= cmd;
            src_prev_reg <= src;
            // Frequency and block gate the run last, so neither can be bypassed
            run_out <= run_req & freq_valid & ~blocked_next;
            reverse_out <= cmd[`CMD_REV_BIT];
            active_run_source <= src;
            freq_override <= fn_keypad_ovr | fn_terminal_ovr;
            if (fn_keypad_ovr) freq_override_source <= `FREQ_KEYPAD_PARAM;
            else if (fn_terminal_ovr) freq_override_source <= `FREQ_TERMINAL_ANALOG;
            else freq_override_source <= `FREQ_NONE;
            // A live key clears a trip; in trip-only mode that is all it does
            trip_clear <= trip_clear_next;
        end
    end
endmodule // run_command_source_arbiter

// File: logic/run_source_consts.vh
`ifndef RUN_SOURCE_CONSTS_VH
`define RUN_SOURCE_CONSTS_VH
// Run-source selection codes
`define SRC_TERMINAL 8'h01
`define SRC_KEYPAD 8'h02
`define SRC_FIELDBUS 8'h03
`define SRC_OPTION 8'h04
// Stop-key enable codes
`define STOPKEY_ALWAYS 8'h00
`define STOPKEY_OFF 8'h01
`define STOPKEY_TRIP_ONLY 8'h02
// Input-terminal function codes
`define FN_FORWARD 8'h00
`define FN_REVERSE 8'h01
`define FN_GO 8'h14
`define FN_HALT 8'h15
`define FN_DIRECTION 8'h16
`define FN_KEYPAD_OVR 8'h1F
`define FN_TERMINAL_OVR 8'h33
// Frequency-source codes shown while an override holds
`define FREQ_KEYPAD_PARAM 8'h02
`define FREQ_TERMINAL_ANALOG 8'h01
`define FREQ_NONE 8'h00
// No source owns the run command yet
`define SRC_NONE 8'h00
// Command word: bit 0 run, bit 1 reverse
`define CMD_RUN_BIT 0
`define CMD_REV_BIT 1
`define CMD_STOP 2'h0
`endif

// File: logic/terminal_function_map.v
`include "run_source_consts.vh"

// Finds which terminal carries a given function; unassigned functions read off
module terminal_function_map #(
    parameter N_TERM = 7
) (
    // Terminal assignment, eight bits per terminal
    input wire [8*N_TERM-1:0] input_function_assign,
    input wire [N_TERM-1:0] term_level,
    // Function levels
    output reg fn_forward,
    output reg fn_reverse,
    output reg fn_go,
    output reg fn_halt,
    output reg fn_direction,
    output reg fn_keypad_ovr,
    output reg fn_terminal_ovr,
    output reg halt_assigned
);
    integer i;
    reg [7:0] code;
    always @* begin
        code = 8'h00;
        fn_forward = 1'b0;
        fn_reverse = 1'b0;
        fn_go = 1'b0;
        fn_halt = 1'b0;
        fn_direction = 1'b0;
        fn_keypad_ovr = 1'b0;
        fn_terminal_ovr = 1'b0;
        halt_assigned = 1'b0;
        for (i = 0; i < N_TERM; i = i + 1) begin
            code = input_function_assign[8*i +: 8];
            if (code == `FN_FORWARD) fn_forward = fn_forward | term_level[i];
            if (code == `FN_REVERSE) fn_reverse = fn_reverse | term_level[i];
            if (code == `FN_GO) fn_go = fn_go | term_level[i];
            if (code == `FN_HALT) begin
                fn_halt = fn_halt | term_level[i];
                halt_assigned = 1'b1;
            end
            if (code == `FN_DIRECTION) fn_direction = fn_direction | term_level[i];
            if (code == `FN_KEYPAD_OVR) fn_keypad_ovr = fn_keypad_ovr | term_level[i];
            if (code == `FN_TERMINAL_OVR) begin
                fn_terminal_ovr = fn_terminal_ovr | term_level[i];
            end
        end
    end
endmodule // terminal_function_map

// File: sim/run_source_checker.sv
module run_source_checker (
    // Clock and settings
    input wire mclk,
    input wire arst_n,
    input wire clk_en,
    input wire [7:0] run_source_select,
    input wire [7:0] stop_key_enable,
    // Sources
    input wire key_stop,
    input wire [1:0] fieldbus_cmd,
    input wire [1:0] option_cmd,
    input wire freq_valid,
    input wire tripped,
    // Outputs
    input wire run_out,
    input wire [7:0] active_run_source,
    input wire freq_override,
    input wire [7:0] freq_override_source,
    input wire trip_clear
);
    timeunit 1ns;
    timeprecision 100ps;
    // Set when the previous edge was enabled, so outputs reflect $past inputs
    reg en_seen_reg;
    always @(posedge mclk or negedge arst_n)
        if (!arst_n) en_seen_reg <= 1'b0;
        else en_seen_reg <= clk_en;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    chk_no_freq_run: assert property (clk_en && !freq_valid |=> !run_out)
        else $error("run without frequency");
    chk_source_follow: assert property (en_seen_reg && !freq_override &&
        $past(run_source_select) inside {[8'h01:8'h04]} |-> active_run_source == $past(run_source_select))
        else $error("source differs from selection");
    chk_override_pair: assert property (freq_override |->
        active_run_source == freq_override_source && freq_override_source inside {8'h01, 8'h02})
        else $error("override sources disagree");
    chk_trip_cause: assert property (en_seen_reg && trip_clear |->
        $past(tripped) && $past(key_stop))
        else $error("trip clear without trip");
    chk_trip_pulse: assert property (trip_clear && clk_en |=> !trip_clear)
        else $error("trip clear too long");
    chk_bus_stop: assert property (en_seen_reg && !freq_override &&
        ($past(run_source_select) == 8'h03 && !$past(fieldbus_cmd[0]) ||
        $past(run_source_select) == 8'h04 && !$past(option_cmd[0])) |-> !run_out)
        else $error("bus stop ignored");
    chk_stop_key: assert property (en_seen_reg && $past(en_seen_reg) &&
        $past(key_stop) && !$past(key_stop, 2) && $past(stop_key_enable) == 8'h00 |-> !run_out)
        else $error("stop key ignored");
    chk_hold_en: assert property (!clk_en |=> $stable(run_out) && $stable(active_run_source))
        else $error("state moved while disabled");
    cover property (trip_clear);
    cover property (freq_override && active_run_source == 8'h02);
    cover property ($fell(run_out) && !freq_override);
endmodule // run_source_checker

bind run_command_source_arbiter run_source_checker i_chk (.mclk, .arst_n, .clk_en,
    .run_source_select, .stop_key_enable, .key_stop, .fieldbus_cmd, .option_cmd, .freq_valid,
    .tripped, .run_out, .active_run_source, .freq_override, .freq_override_source, .trip_clear);

// File: sim/field_side_model.sv
// Terminal block, keypad and both buses, as plain levels set by the bench
module field_side_model (
    // Requests
    input logic [6:0] term_req,
    input logic [2:0] key_req,
    input logic [1:0] fb_req,
    input logic [1:0] op_req,
    // Toward the arbiter
    output logic [6:0] term_level,
    output logic key_run,
    output logic key_stop,
    output logic key_reverse,
    output logic [1:0] fieldbus_cmd,
    output logic [1:0] option_cmd
);
    timeunit 1ns;
    timeprecision 100ps;
    assign term_level = term_req;
    assign {key_reverse, key_stop, key_run} = key_req;
    // External run is dropped and raised again to leave a block
    assign fieldbus_cmd = fb_req;
    assign option_cmd = op_req;
endmodule // field_side_model

// File: sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, freq_valid = 1'b0, tripped = 1'b0;
    logic [7:0] sel = 8'h03, ske = 8'h00;
    logic [55:0] ifa = {8'h0A, 8'h0A, 8'h0A, 8'h33, 8'h1F, 8'h01, 8'h00};
    logic [6:0] term_req = 7'h00, term_level;
    logic [2:0] key_req = 3'h0;
    logic [1:0] fb_req = 2'h0, op_req = 2'h0, fieldbus_cmd, option_cmd;
    logic key_run, key_stop, key_reverse, run_out, reverse_out, freq_override, trip_clear;
    logic [7:0] active_run_source, freq_override_source;
    int failures = 0, checked = 0, r, e;
    run_command_source_arbiter #(.N_TERM(7)) i_dut (.mclk, .arst_n, .clk_en,
        .run_source_select(sel), .stop_key_enable(ske), .input_function_assign(ifa),
        .term_level, .key_run, .key_stop, .key_reverse, .fieldbus_cmd, .option_cmd, .freq_valid,
        .tripped, .run_out, .reverse_out, .active_run_source, .freq_override,
        .freq_override_source, .trip_clear);
    field_side_model i_far (.term_req, .key_req, .fb_req, .op_req, .term_level, .key_run,
        .key_stop, .key_reverse, .fieldbus_cmd, .option_cmd);
    ////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Two-wire and bus sources; bit 0 run, bit 1 reverse
    function automatic int model(int s, int t, int f, int o);
        int c;
        c = s == 1 ? (t == 1 ? 1 : t == 2 ? 3 : 0) : s == 3 ? f : s == 4 ? o : 0;
        return (freq_valid && c[0]) ? c : 0;
    endfunction
    task automatic results;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial forever #2 mclk = ~mclk;
    initial begin
        #20000;
        failures++;
        results();
    end
    initial begin
        step(16);
        arst_n = 1'b1;
        r = $urandom(50);
        for (int i = 0; i < 24; i++) begin
            r = $urandom;
            sel = r[1] ? 8'h03 + {7'h00, r[0]} : 8'h01;
            term_req = {r[6:4], 2'h0, r[3:2]};
            fb_req = r[8:7];
            op_req = r[10:9];
            freq_valid = r[11] | r[12];
            step(1);
            e = model(sel, term_req[1:0], fb_req, op_req);
            cmp({7'h00, run_out}, 8'(e[0]));
            if (e[0]) cmp({7'h00, reverse_out}, 8'(e[1]));
            cmp(active_run_source, sel);
        end
        $display("test sources done");
        {sel, term_req, fb_req, freq_valid} = {8'h03, 7'h00, 2'h1, 1'b1};
        for (int m = 0; m < 4; m++) begin
            ske = m == 3 ? 8'h02 : 8'(m);
            tripped = m != 3;
            key_req = 3'h2;
            step(1);
            cmp({7'h00, trip_clear}, 8'(m == 0 || m == 2));
            cmp({7'h00, run_out}, 8'(m != 0));
            step(1);
            key_req = 3'h0;
            step(1);
            cmp({7'h00, run_out}, 8'(m != 0));
            fb_req = 2'h0;
            step(1);
            fb_req = 2'h1;
            step(1);
            cmp({7'h00, run_out}, 8'h01);
        end
        $display("test stop key done");
        term_req = 7'h08;
        step(1);
        cmp(freq_override_source, 8'h01);
        cmp({7'h00, run_out}, 8'h00);
        term_req = 7'h09;
        step(1);
        cmp({7'h00, run_out}, 8'h01);
        term_req = 7'h0D;
        step(1);
        cmp(active_run_source, 8'h02);
        cmp(freq_override_source, 8'h02);
        key_req = 3'h5;
        step(2);
        cmp({6'h00, reverse_out, run_out}, 8'h03);
        {key_req, term_req} = 10'h000;
        step(1);
        cmp({freq_override, active_run_source[6:0]}, 8'h03);
        cmp({7'h00, run_out}, 8'h00);
        $display("test overrides done");
        clk_en = 1'b0;
        step(2);
        cmp(active_run_source, 8'h03);
        clk_en = 1'b1;
        step(1);
        cmp({7'h00, run_out}, 8'h00);
        $display("test enable done");
        // Three-wire control on terminals 0 to 2; overrides left unassigned
        ifa = {8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h16, 8'h15, 8'h14};
        sel = 8'h01;
        term_req = 7'h02;
        step(1);
        term_req = 7'h03;
        step(2);
        cmp({6'h00, reverse_out, run_out}, 8'h01);
        term_req = 7'h06;
        step(1);
        cmp({6'h00, reverse_out, run_out}, 8'h03);
        term_req = 7'h7C;
        step(2);
        cmp({7'h00, run_out}, 8'h00);
        cmp({7'h00, freq_override}, 8'h00);
        $display("test three-wire done");
        term_req = 7'h00;
        sel = 8'h02;
        ske = 8'h01;
        key_req = 3'h1;
        step(2);
        cmp(active_run_source, 8'h02);
        cmp({7'h00, run_out}, 8'h01);
        key_req = 3'h2;
        step(1);
        cmp({7'h00, run_out}, 8'h00);
        $display("test keypad source done");
        results();
    end
endmodule // testbench
